// File: design/mie_pkg.sv
// Shared types and constants of the instruction execute unit.
package mie_pkg;
	// Width of the program counter and of each stack entry.
	localparam int PC_W = 16;
	// Number of return addresses the hardware stack holds.
	localparam int STACK_DEPTH = 8;
	// Width of the stack pointer.
	localparam int SP_W = 3;
	// Step of the stack pointer on a push or a pop.
	localparam logic [SP_W-1:0] SP_STEP = 3'h1;
	// Data memory address that aliases the low byte of the program counter.
	localparam logic [7:0] PC_LOW_BYTE_ADDR = 8'h02;
	// Program counter after reset.
	localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
	// Address the core jumps to when it takes an interrupt.
	localparam logic [PC_W-1:0] IRQ_VECTOR = 16'h0004;
	// Step of the program counter to the following instruction.
	localparam logic [PC_W-1:0] PC_STEP = 16'h0001;
	// Byte of all zeros, used by clear and by the zero test.
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	// Byte of value one, used by increment, decrement and bit masks.
	localparam logic [7:0] BYTE_ONE = 8'h01;
	// Largest nibble that is still a decimal digit.
	localparam logic [3:0] BCD_MAX = 4'h9;
	// Correction added to the low nibble by the decimal adjust.
	localparam logic [7:0] ADJ_LOW = 8'h06;
	// Correction added to the high nibble by the decimal adjust.
	localparam logic [7:0] ADJ_HIGH = 8'h60;

	// Operations of the core, decoded from program memory by the fetcher.
	typedef enum logic [4:0] {
		OP_NOP, OP_ADD_MEM, OP_ADD_CARRY, OP_ADD_IMM, OP_AND_MEM,
		OP_AND_IMM, OP_OR_MEM, OP_OR_IMM, OP_COMPLEMENT, OP_DECREMENT,
		OP_INCREMENT, OP_DECIMAL_ADJUST, OP_CLEAR, OP_CLEAR_BIT,
		OP_MOVE_TO_ACC, OP_MOVE_IMM, OP_MOVE_TO_MEM, OP_ROTATE_LEFT,
		OP_CALL, OP_JUMP, OP_RETURN, OP_RETURN_IMM, OP_RETURN_INT,
		OP_WDOG_CLEAR, OP_PRECLEAR_FIRST, OP_PRECLEAR_SECOND, OP_HALT
	} mie_op_e;

	// Which pre-clear instruction ran last without its partner.
	typedef enum logic [1:0] {PRE_NONE, PRE_FIRST, PRE_SECOND} mie_pre_e;

	// Arithmetic status flags.
	typedef struct packed {
		logic overflow;
		logic zero;
		logic aux_carry;
		logic carry;
	} mie_flags_s;

	// One decoded instruction with all its operands.
	typedef struct packed {
		mie_op_e op;
		logic dest_mem;
		logic [7:0] addr;
		logic [7:0] imm;
		logic [2:0] bit_sel;
		logic [PC_W-1:0] target;
	} mie_instr_s;

	// One write to data memory.
	typedef struct packed {
		logic we;
		logic [7:0] addr;
		logic [7:0] data;
	} mie_mwr_s;
endpackage

// File: design/mie_alu.sv
// Data path of the execute unit: results and new flags per operation.
`timescale 1ns/1ns
module mie_alu
	import mie_pkg::*;
(
	input wire mie_pkg::mie_op_e op,
	input wire logic [7:0] acc,
	input wire logic [7:0] mem,
	input wire logic [7:0] imm,
	input wire logic [2:0] bit_sel,
	input wire mie_pkg::mie_flags_s flags_i,
	output logic [7:0] res,
	output mie_pkg::mie_flags_s flags_o
);
	// Result of an addition with its three carry related flags.
	typedef struct packed {
		logic [7:0] sum;
		logic overflow;
		logic aux_carry;
		logic carry;
	} mie_sum_s;

	// Eight bit addition with carry in and the flags it produces.
	function automatic mie_sum_s add8(input logic [7:0] a,
		input logic [7:0] b, input logic cin);
		logic [4:0] low;
		logic [8:0] full;
		mie_sum_s r;
		low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		r.sum = full[7:0];
		r.aux_carry = low[4];
		r.carry = full[8];
		r.overflow = (a[7] == b[7]) && (full[7] != a[7]);
		return r;
	endfunction

	// True when a byte is all zero.
	function automatic logic is_zero(input logic [7:0] b);
		return b == BYTE_ZERO;
	endfunction

	mie_sum_s s; // Adder output for the arithmetic operations.
	logic adj_lo; // Low nibble needs decimal correction.
	logic adj_hi; // High nibble needs decimal correction.

	// Unchanged flags are copied, so the caller may always take flags_o.
	always_comb begin
		s = add8(acc, mem, 1'b0);
		adj_lo = (acc[3:0] > BCD_MAX) || flags_i.aux_carry;
		adj_hi = (acc[7:4] > BCD_MAX) || flags_i.carry;
		res = acc;
		flags_o = flags_i;
		case (op)
			OP_ADD_MEM, OP_ADD_CARRY, OP_ADD_IMM: begin
				// Carry in only for the carry form.
				s = add8(acc, (op == OP_ADD_IMM) ? imm : mem,
					(op == OP_ADD_CARRY) && flags_i.carry);
				res = s.sum;
				flags_o = '{s.overflow, is_zero(s.sum), s.aux_carry,
					s.carry};
			end
			OP_AND_MEM, OP_AND_IMM: begin
				res = acc & ((op == OP_AND_IMM) ? imm : mem);
				flags_o.zero = is_zero(res);
			end
			OP_OR_MEM, OP_OR_IMM: begin
				res = acc | ((op == OP_OR_IMM) ? imm : mem);
				flags_o.zero = is_zero(res);
			end
			OP_COMPLEMENT: begin
				res = ~mem;
				flags_o.zero = is_zero(res);
			end
			OP_DECREMENT: begin
				res = mem - BYTE_ONE;
				flags_o.zero = is_zero(res);
			end
			OP_INCREMENT: begin
				res = mem + BYTE_ONE;
				flags_o.zero = is_zero(res);
			end
			OP_DECIMAL_ADJUST: begin
				// Corrections chosen from the original value.
				s = add8(acc, (adj_lo ? ADJ_LOW : BYTE_ZERO) |
					(adj_hi ? ADJ_HIGH : BYTE_ZERO), 1'b0);
				res = s.sum;
				flags_o.carry = flags_i.carry || adj_hi || s.carry;
			end
			OP_CLEAR: res = BYTE_ZERO;
			OP_CLEAR_BIT: res = mem & ~(BYTE_ONE << bit_sel);
			OP_MOVE_TO_ACC: res = mem;
			OP_MOVE_IMM, OP_RETURN_IMM: res = imm;
			OP_ROTATE_LEFT: res = {mem[6:0], mem[7]};
			default: res = acc;
		endcase
	end
endmodule

// File: design/mie_core.sv
// Execute unit of the eight bit core: state, sequencing and checks.
`timescale 1ns/1ns
module mie_core
	import mie_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic instr_valid,
	input wire mie_pkg::mie_instr_s instr,
	input wire logic [7:0] mem_rdata,
	input wire logic irq_req,
	input wire logic wake_req,
	input wire logic wdt_timeout_evt,
	output logic ready,
	output logic [mie_pkg::PC_W-1:0] pc,
	output logic [7:0] acc,
	output mie_pkg::mie_flags_s flags,
	output logic global_interrupt_enable,
	output logic watchdog_timeout_flag,
	output logic powerdown_flag,
	output logic halted,
	output logic watchdog_clear,
	output mie_pkg::mie_mwr_s mem_wr
);
	import mie_pkg::*;

	// Everything the unit remembers between clock edges.
	typedef struct packed {
		logic [PC_W-1:0] pc;
		logic [7:0] acc;
		mie_flags_s flags;
		logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
		logic [SP_W-1:0] sp;
		logic gie;
		logic timeout;
		logic pdown;
		logic halted;
		logic ready;
		logic wdt_clear;
		mie_pre_e pre_last;
		mie_mwr_s mwr;
	} mie_state_s;

	mie_state_s s_q; // Registered state.
	mie_state_s s_d; // Next state.
	logic [1:0] rst_sync_q; // Reset release synchroniser.
	logic rst_n; // Synchronised reset used by the rest of the unit.
	logic take; // An instruction is executed in this cycle.
	logic irq_take; // An interrupt is entered in this cycle.
	logic [7:0] alu_res; // Result from the data path.
	mie_flags_s alu_flags; // Flags from the data path.
	logic pre_fire; // A pre-clear completes its pair.
	logic [7:0] mem_op; // Operand byte, with a pending write forwarded.

	// Reset asserts at once and releases after two clock edges.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// A registered write lands in memory only at the next edge, so an
	// instruction right behind it would read the stale byte. The pending
	// write is forwarded when it targets the byte now addressed.
	always_comb begin
		mem_op = mem_rdata;
		if (s_q.mwr.we && s_q.mwr.addr == instr.addr) begin
			mem_op = s_q.mwr.data;
		end
	end

	// The data path sees the operand byte addressed by this instruction.
	mie_alu u_alu (
		.op(instr.op),
		.acc(s_q.acc),
		.mem(mem_op),
		.imm(instr.imm),
		.bit_sel(instr.bit_sel),
		.flags_i(s_q.flags),
		.res(alu_res),
		.flags_o(alu_flags)
	);

	// Next state: interrupt entry, instruction execution and flag updates.
	always_comb begin
		s_d = s_q;
		s_d.wdt_clear = 1'b0;
		s_d.mwr.we = 1'b0;
		s_d.ready = 1'b1;
		take = 1'b0;
		pre_fire = 1'b0;
		irq_take = s_q.gie && irq_req && s_q.ready && !s_q.halted;
		if (s_q.halted) begin
			// Clock stopped: only a wake request or a time-out restarts.
			s_d.ready = wake_req || wdt_timeout_evt;
			if (wake_req || wdt_timeout_evt) begin
				s_d.halted = 1'b0;
			end
		end else if (!s_q.ready) begin
			// Dummy cycle of a two cycle instruction.
			s_d.ready = 1'b1;
		end else if (irq_take) begin
			// A pending interrupt is served before the next instruction,
			// also right after an interrupt return.
			s_d.stack[s_q.sp] = s_q.pc;
			s_d.sp = s_q.sp + SP_STEP;
			s_d.pc = IRQ_VECTOR;
			s_d.gie = 1'b0;
			s_d.ready = 1'b0;
		end else if (instr_valid) begin
			take = 1'b1;
			s_d.pc = s_q.pc + PC_STEP;
			case (instr.op)
				OP_ADD_MEM, OP_ADD_CARRY, OP_AND_MEM, OP_OR_MEM,
				OP_COMPLEMENT, OP_DECREMENT, OP_INCREMENT: begin
					// Destination chosen by the instruction.
					s_d.flags = alu_flags;
					if (instr.dest_mem) begin
						s_d.mwr = '{1'b1, instr.addr, alu_res};
					end else begin
						s_d.acc = alu_res;
					end
				end
				OP_ADD_IMM, OP_AND_IMM, OP_OR_IMM: begin
					// Immediate forms always write the accumulator.
					s_d.flags = alu_flags;
					s_d.acc = alu_res;
				end
				OP_DECIMAL_ADJUST: begin
					// Result to memory, only carry may change.
					s_d.flags = alu_flags;
					s_d.mwr = '{1'b1, instr.addr, alu_res};
				end
				OP_CLEAR, OP_CLEAR_BIT, OP_ROTATE_LEFT: begin
					// Memory written, flags untouched.
					s_d.mwr = '{1'b1, instr.addr, alu_res};
				end
				OP_MOVE_TO_MEM: begin
					s_d.mwr = '{1'b1, instr.addr, s_q.acc};
				end
				OP_MOVE_TO_ACC, OP_MOVE_IMM: begin
					s_d.acc = alu_res;
				end
				OP_CALL: begin
					// Push the following address, then branch.
					s_d.stack[s_q.sp] = s_q.pc + PC_STEP;
					s_d.sp = s_q.sp + SP_STEP;
					s_d.pc = instr.target;
					s_d.ready = 1'b0;
				end
				OP_JUMP: begin
					s_d.pc = instr.target;
					s_d.ready = 1'b0;
				end
				OP_RETURN, OP_RETURN_IMM, OP_RETURN_INT: begin
					// Pop the return address.
					s_d.sp = s_q.sp - SP_STEP;
					s_d.pc = s_q.stack[s_q.sp - SP_STEP];
					s_d.ready = 1'b0;
					if (instr.op == OP_RETURN_IMM) begin
						s_d.acc = alu_res;
					end
					if (instr.op == OP_RETURN_INT) begin
						s_d.gie = 1'b1;
					end
				end
				OP_WDOG_CLEAR: begin
					// Single clear acts at once.
					s_d.wdt_clear = 1'b1;
					s_d.timeout = 1'b0;
					s_d.pdown = 1'b0;
					s_d.pre_last = PRE_NONE;
				end
				OP_PRECLEAR_FIRST: begin
					// Acts only after its partner.
					pre_fire = s_q.pre_last == PRE_SECOND;
					s_d.pre_last = pre_fire ? PRE_NONE : PRE_FIRST;
				end
				OP_PRECLEAR_SECOND: begin
					// Acts only after its partner.
					pre_fire = s_q.pre_last == PRE_FIRST;
					s_d.pre_last = pre_fire ? PRE_NONE : PRE_SECOND;
				end
				OP_HALT: begin
					// Stop, clear the watchdog, mark power-down.
					s_d.halted = 1'b1;
					s_d.ready = 1'b0;
					s_d.wdt_clear = 1'b1;
					s_d.pdown = 1'b1;
					s_d.timeout = 1'b0;
				end
				default: begin
					// No operation: only the counter advances.
					s_d.pc = s_q.pc + PC_STEP;
				end
			endcase
			if (pre_fire) begin
				// Completed pair clears the watchdog.
				s_d.wdt_clear = 1'b1;
				s_d.timeout = 1'b0;
				s_d.pdown = 1'b0;
			end
			if (s_d.mwr.we && instr.addr == PC_LOW_BYTE_ADDR) begin
				// Memory alias of the counter low byte.
				s_d.pc = {s_q.pc[PC_W-1:8], s_d.mwr.data};
				s_d.ready = 1'b0;
			end
		end
		// A time-out in the same cycle as a clear wins.
		if (wdt_timeout_evt) begin
			s_d.timeout = 1'b1;
		end
	end

	// State register.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.pc <= PC_RESET;
			s_q.pre_last <= PRE_NONE;
			s_q.ready <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs come straight from the state register.
	assign ready = s_q.ready;
	assign pc = s_q.pc;
	assign acc = s_q.acc;
	assign flags = s_q.flags;
	assign global_interrupt_enable = s_q.gie;
	assign watchdog_timeout_flag = s_q.timeout;
	assign powerdown_flag = s_q.pdown;
	assign halted = s_q.halted;
	assign watchdog_clear = s_q.wdt_clear;
	assign mem_wr = s_q.mwr;

	// Checks of the execution results.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// Add with carry into the accumulator.
	a_add_carry_acc: assert property (
		take && instr.op == OP_ADD_CARRY && !instr.dest_mem |=>
		s_q.acc == 8'($past(s_q.acc) + $past(mem_op) +
		{7'h00, $past(s_q.flags.carry)}))
		else $error("add with carry result wrong");

	// Logic operations keep carry and overflow.
	a_and_flags: assert property (
		take && instr.op inside {OP_AND_MEM, OP_AND_IMM, OP_OR_MEM,
		OP_OR_IMM} |=> $stable(s_q.flags.carry) &&
		$stable(s_q.flags.overflow) && $stable(s_q.flags.aux_carry))
		else $error("logic operation changed carry flags");

	// Call pushes the next address and waits one dummy cycle.
	a_call_push: assert property (
		take && instr.op == OP_CALL |=> !ready &&
		pc == $past(instr.target) &&
		s_q.stack[$past(s_q.sp)] == 16'($past(s_q.pc) + PC_STEP)
		##1 ready) else $error("call sequence wrong");

	// Clear writes a zero byte.
	a_clear_zero: assert property (
		take && instr.op == OP_CLEAR |=> mem_wr.we &&
		mem_wr.data == BYTE_ZERO && $stable(s_q.flags))
		else $error("clear did not write zero");

	// Single watchdog clear drops both flags.
	a_wdog_clear: assert property (
		take && instr.op == OP_WDOG_CLEAR && !wdt_timeout_evt |=>
		watchdog_clear && !watchdog_timeout_flag && !powerdown_flag)
		else $error("watchdog clear had no effect");

	// A first pre-clear not preceded by its partner does nothing.
	a_pre_repeat: assert property (
		take && instr.op == OP_PRECLEAR_FIRST &&
		s_q.pre_last != PRE_SECOND |=> !watchdog_clear &&
		$stable(powerdown_flag)) else $error("lone pre-clear acted");

	// Halt stops execution and marks power-down.
	a_halt_entry: assert property (
		take && instr.op == OP_HALT |=> halted && powerdown_flag &&
		!ready && watchdog_clear) else $error("halt entry wrong");

	// Jump takes two cycles.
	a_jump_two: assert property (
		take && instr.op == OP_JUMP |=> !ready &&
		pc == $past(instr.target) ##1 ready)
		else $error("jump timing wrong");

	// No operation changes nothing but the counter.
	a_nop_quiet: assert property (
		take && instr.op == OP_NOP |=> $stable(acc) && $stable(flags)
		&& !mem_wr.we && pc == 16'($past(pc) + PC_STEP))
		else $error("no operation changed state");

	// Interrupt return enables interrupts again.
	a_return_from_interrupt_gie: assert property (
		take && instr.op == OP_RETURN_INT |=> global_interrupt_enable)
		else $error("interrupt return left interrupts off");

	// Rotate left moves bit seven into bit zero.
	a_rotate_left: assert property (
		take && instr.op == OP_ROTATE_LEFT |=> mem_wr.we &&
		mem_wr.data == {$past(mem_op[6:0]), $past(mem_op[7])})
		else $error("rotate left result wrong");

	// Writes to the counter low byte stall one cycle.
	a_low_byte_stall: assert property (
		take && instr.op == OP_MOVE_TO_MEM &&
		instr.addr == PC_LOW_BYTE_ADDR |=> !ready &&
		pc[7:0] == $past(acc)) else $error("low byte write not stalled");

	// Plain add leaves the carry flag out of the sum.
	a_add_no_carry: assert property (
		take && instr.op == OP_ADD_MEM && !instr.dest_mem |=>
		s_q.acc == 8'($past(s_q.acc) + $past(mem_op)))
		else $error("plain add used the carry");

	// Complement, increment and decrement keep the carry related flags.
	a_unary_flags: assert property (
		take && instr.op inside {OP_COMPLEMENT, OP_INCREMENT,
		OP_DECREMENT} |=> $stable(s_q.flags.carry) &&
		$stable(s_q.flags.aux_carry) && $stable(s_q.flags.overflow))
		else $error("unary operation changed carry flags");

	// Decimal adjust writes memory and changes at most the carry flag.
	a_daa_flags: assert property (
		take && instr.op == OP_DECIMAL_ADJUST |=> mem_wr.we &&
		$stable(acc) && $stable(s_q.flags.zero) &&
		$stable(s_q.flags.aux_carry) && $stable(s_q.flags.overflow))
		else $error("decimal adjust changed other state");

	// Moves leave every flag as it was.
	a_move_flags: assert property (
		take && instr.op inside {OP_MOVE_TO_ACC, OP_MOVE_IMM,
		OP_MOVE_TO_MEM} |=> $stable(flags))
		else $error("move changed a flag");

	// Plain return reloads the counter from the top of the stack.
	a_return_pop: assert property (
		take && instr.op == OP_RETURN |=> !ready &&
		pc == $past(s_q.stack[s_q.sp - SP_STEP]) && $stable(flags))
		else $error("return address wrong");
endmodule

// File: sim/mie_dmem_model.sv
// Behavioural data memory that answers the execute unit.
`timescale 1ns/1ns
module mie_dmem_model
	import mie_pkg::*;
(
	input wire logic sys_clk,
	input wire logic [7:0] rd_addr,
	input wire mie_pkg::mie_mwr_s mem_wr,
	output logic [7:0] rd_data
);
	// Storage of 256 bytes, cleared at time zero so no read is unknown.
	logic [7:0] store [256];
	initial begin
		for (int i = 0; i < 256; i++) begin
			store[i] = 8'h00;
		end
	end
	// Reads are combinational, as the core expects them in the same cycle.
	assign rd_data = store[rd_addr];
	// A write pulse lands at the rising edge that ends its cycle.
	always @(posedge sys_clk) begin
		if (mem_wr.we) begin
			store[mem_wr.addr] <= mem_wr.data;
		end
	end
endmodule

// File: sim/tb_top.sv
// Self-checking bench of the execute unit with a data memory model.
`timescale 1ns/1ns
module tb_top;
	import mie_pkg::*;
	// Inputs of the core, all given a value at time zero.
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic instr_valid = 1'b0;
	mie_instr_s instr = '0;
	logic irq_req = 1'b0;
	logic wake_req = 1'b0;
	logic wdt_timeout_evt = 1'b0;
	// Outputs of the core and the memory read data.
	logic [7:0] mem_rdata;
	logic ready;
	logic [PC_W-1:0] pc;
	logic [7:0] acc;
	mie_flags_s flags;
	logic global_interrupt_enable;
	logic watchdog_timeout_flag;
	logic powerdown_flag;
	logic halted;
	logic watchdog_clear;
	mie_mwr_s mem_wr;
	// Counters of mismatches, comparisons and elapsed cycles.
	int failures = 0;
	int tests_run = 0;
	int cycles = 0;

	// The clock toggles every half period of 25 ns.
	always #25 sys_clk = ~sys_clk;

	mie_core i_dut (.sys_clk, .resetn, .instr_valid, .instr, .mem_rdata,
		.irq_req, .wake_req, .wdt_timeout_evt, .ready, .pc, .acc, .flags,
		.global_interrupt_enable, .watchdog_timeout_flag, .powerdown_flag,
		.halted, .watchdog_clear, .mem_wr);

	mie_dmem_model i_mem (.sys_clk, .rd_addr(instr.addr), .mem_wr,
		.rd_data(mem_rdata));

	// Prints the counts and the verdict, then ends the run.
	task automatic final_report();
		$display("Comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// A hang is cut short well after the sequence should have finished.
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			failures++;
			final_report();
		end
	end

	// Compares a seen value with the expected one and counts the result.
	task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Issues one instruction; returns at the negedge where results show.
	task automatic do_op(mie_op_e o, logic d, logic [7:0] a, logic [7:0] i,
		logic [2:0] b = 3'h0, logic [15:0] t = 16'h0000);
		int n;
		n = 0;
		while (!(ready === 1'b1 && halted === 1'b0) && n < 20) begin
			@(negedge sys_clk);
			n++;
		end
		chk("ready_before", ready, 1'b1);
		instr = '{op: o, dest_mem: d, addr: a, imm: i, bit_sel: b, target: t};
		instr_valid = 1'b1;
		@(posedge sys_clk);
		// Lowered on the edge so the next request never lands in one step.
		instr_valid <= 1'b0;
		@(negedge sys_clk);
	endtask

	// Raises the watchdog time-out event for one cycle.
	task automatic pulse_timeout();
		wdt_timeout_evt = 1'b1;
		@(negedge sys_clk);
		wdt_timeout_evt = 1'b0;
		chk("timeout_set", watchdog_timeout_flag, 1'b1);
	endtask

	// Additions with and without carry, overflow and memory result.
	task automatic s_arith();
		do_op(OP_MOVE_IMM, 1'b0, 8'h00, 8'h80);
		chk("mov_imm", {acc, flags}, 12'h800);
		do_op(OP_ADD_IMM, 1'b0, 8'h00, 8'h80);
		chk("add_imm", {acc, flags}, 12'h00D);
		do_op(OP_MOVE_IMM, 1'b0, 8'h00, 8'h3C);
		do_op(OP_MOVE_TO_MEM, 1'b1, 8'h10, 8'h00);
		chk("mov_mem", mem_wr, {1'b1, 8'h10, 8'h3C});
		chk("mov_mem_f", flags, 4'hD);
		do_op(OP_ADD_CARRY, 1'b1, 8'h10, 8'h00);
		chk("adc_wr", mem_wr, {1'b1, 8'h10, 8'h79});
		chk("adc_acc", {acc, flags}, 12'h3C2);
	endtask

	// Logic operations touch only the zero flag.
	task automatic s_logic();
		do_op(OP_AND_IMM, 1'b0, 8'h00, 8'hC3);
		chk("and_imm", {acc, flags}, 12'h006);
		do_op(OP_OR_MEM, 1'b1, 8'h10, 8'h00);
		chk("or_wr", mem_wr, {1'b1, 8'h10, 8'h79});
		chk("or_acc", {acc, flags}, 12'h002);
		do_op(OP_OR_IMM, 1'b0, 8'h00, 8'h81);
		chk("or_imm", {acc, flags}, 12'h812);
	endtask

	// Unary operations on memory: complement, step, rotate and clear.
	task automatic s_unary();
		do_op(OP_COMPLEMENT, 1'b0, 8'h10, 8'h00);
		chk("cpl_acc", {mem_wr.we, acc, flags}, 13'h0862);
		do_op(OP_COMPLEMENT, 1'b1, 8'h10, 8'h00);
		chk("cpl_mem", mem_wr, {1'b1, 8'h10, 8'h86});
		do_op(OP_DECREMENT, 1'b1, 8'h10, 8'h00);
		chk("dec_mem", mem_wr, {1'b1, 8'h10, 8'h85});
		do_op(OP_INCREMENT, 1'b0, 8'h10, 8'h00);
		chk("inc_acc", {mem_wr.we, acc}, 9'h086);
		do_op(OP_MOVE_IMM, 1'b0, 8'h00, 8'hFF);
		do_op(OP_MOVE_TO_MEM, 1'b1, 8'h11, 8'h00);
		do_op(OP_INCREMENT, 1'b1, 8'h11, 8'h00);
		chk("inc_wrap", mem_wr, {1'b1, 8'h11, 8'h00});
		chk("inc_zero", flags, 4'h6);
		do_op(OP_MOVE_IMM, 1'b0, 8'h00, 8'h81);
		do_op(OP_MOVE_TO_MEM, 1'b1, 8'h12, 8'h00);
		do_op(OP_ROTATE_LEFT, 1'b1, 8'h12, 8'h00);
		chk("rol", mem_wr, {1'b1, 8'h12, 8'h03});
		chk("rol_f", flags, 4'h6);
		do_op(OP_CLEAR, 1'b1, 8'h12, 8'h00);
		chk("clr", {mem_wr, flags}, {1'b1, 8'h12, 8'h00, 4'h6});
		do_op(OP_CLEAR_BIT, 1'b1, 8'h10, 8'h00, 3'h2);
		chk("clr_bit", {mem_wr, flags}, {1'b1, 8'h10, 8'h81, 4'h6});
	endtask

	// Decimal adjust by aux carry and by a high nibble above nine.
	task automatic s_decimal();
		do_op(OP_MOVE_IMM, 1'b0, 8'h00, 8'h48);
		do_op(OP_ADD_IMM, 1'b0, 8'h00, 8'h49);
		do_op(OP_DECIMAL_ADJUST, 1'b1, 8'h13, 8'h00);
		chk("daa_low", mem_wr, {1'b1, 8'h13, 8'h97});
		chk("daa_low_f", {acc, flags}, 12'h91A);
		do_op(OP_MOVE_IMM, 1'b0, 8'h00, 8'hA0);
		do_op(OP_ADD_IMM, 1'b0, 8'h00, 8'h00);
		do_op(OP_DECIMAL_ADJUST, 1'b1, 8'h13, 8'h00);
		chk("daa_high", mem_wr, {1'b1, 8'h13, 8'h00});
		chk("daa_high_f", {acc, flags}, 12'hA01);
	endtask

	// Jump, call, return and no-operation, with their dummy cycles.
	task automatic s_flow();
		do_op(OP_JUMP, 1'b0, 8'h00, 8'h00, 3'h0, 16'h0100);
		chk("jmp", {pc, ready}, {16'h0100, 1'b0});
		@(negedge sys_clk);
		chk("jmp_ready", ready, 1'b1);
		do_op(OP_CALL, 1'b0, 8'h00, 8'h00, 3'h0, 16'h0200);
		chk("call", {pc, ready, flags}, {16'h0200, 1'b0, 4'h1});
		do_op(OP_RETURN_IMM, 1'b0, 8'h00, 8'h5A);
		chk("ret_imm", {pc, acc, flags}, {16'h0101, 8'h5A, 4'h1});
		do_op(OP_NOP, 1'b0, 8'h00, 8'h00);
		chk("nop", {pc, acc, flags, mem_wr.we},
			{16'h0102, 8'h5A, 4'h1, 1'b0});
	endtask

	// Interrupt return enables interrupts and a pending one is served first.
	task automatic s_irq();
		int n;
		do_op(OP_CALL, 1'b0, 8'h00, 8'h00, 3'h0, 16'h0300);
		irq_req = 1'b1;
		do_op(OP_RETURN_INT, 1'b0, 8'h00, 8'h00);
		chk("return_from_interrupt", {pc, global_interrupt_enable}, 17'h0_0207);
		n = 0;
		while (pc !== IRQ_VECTOR && n < 6) begin
			@(negedge sys_clk);
			n++;
		end
		chk("irq_entry", {pc, global_interrupt_enable}, 17'h0_0008);
		irq_req = 1'b0;
		do_op(OP_RETURN_INT, 1'b0, 8'h00, 8'h00);
		chk("return_from_interrupt_back", {pc, global_interrupt_enable}, 17'h0_0207);
	endtask

	// Writing the counter low byte costs a dummy cycle.
	task automatic s_low_byte();
		do_op(OP_MOVE_IMM, 1'b0, 8'h00, 8'h40);
		do_op(OP_MOVE_TO_MEM, 1'b1, PC_LOW_BYTE_ADDR, 8'h00);
		chk("pcl_wr", mem_wr, {1'b1, 8'h02, 8'h40});
		chk("pcl", {pc[7:0], ready}, 9'h080);
	endtask

	// Power-down, wake-up, watchdog clear and the pre-clear pairing.
	task automatic s_watchdog();
		pulse_timeout();
		do_op(OP_HALT, 1'b0, 8'h00, 8'h00);
		chk("halt", {halted, powerdown_flag, watchdog_timeout_flag,
			watchdog_clear, ready}, 5'b11010);
		repeat (3) @(negedge sys_clk);
		chk("halt_hold", {halted, acc}, 9'h140);
		wake_req = 1'b1;
		@(negedge sys_clk);
		wake_req = 1'b0;
		@(negedge sys_clk);
		chk("wake", {halted, ready}, 2'b01);
		pulse_timeout();
		do_op(OP_WDOG_CLEAR, 1'b0, 8'h00, 8'h00);
		chk("wdog_clr", {watchdog_timeout_flag, powerdown_flag,
			watchdog_clear}, 3'b001);
		pulse_timeout();
		do_op(OP_PRECLEAR_FIRST, 1'b0, 8'h00, 8'h00);
		chk("pre1", {watchdog_timeout_flag, watchdog_clear}, 2'b10);
		do_op(OP_PRECLEAR_FIRST, 1'b0, 8'h00, 8'h00);
		chk("pre1_again", {watchdog_timeout_flag, watchdog_clear}, 2'b10);
		do_op(OP_PRECLEAR_SECOND, 1'b0, 8'h00, 8'h00);
		chk("pre_pair", {watchdog_timeout_flag, watchdog_clear}, 2'b01);
		pulse_timeout();
		do_op(OP_PRECLEAR_SECOND, 1'b0, 8'h00, 8'h00);
		chk("pre2_alone", {watchdog_timeout_flag, watchdog_clear}, 2'b10);
	endtask

	// Memory forms of add, add with carry and AND, then a plain return.
	task automatic s_mem_ops();
		do_op(OP_MOVE_TO_ACC, 1'b0, 8'h10, 8'h00);
		chk("mov_acc", {acc, flags}, {8'h81, 4'h1});
		do_op(OP_ADD_MEM, 1'b0, 8'h10, 8'h00);
		chk("add_mem", {acc, flags}, {8'h02, 4'h9});
		do_op(OP_ADD_CARRY, 1'b0, 8'h10, 8'h00);
		chk("adc_to_acc", {acc, flags}, {8'h84, 4'h0});
		do_op(OP_AND_MEM, 1'b1, 8'h10, 8'h00);
		chk("and_mem", mem_wr, {1'b1, 8'h10, 8'h80});
		do_op(OP_DECREMENT, 1'b0, 8'h10, 8'h00);
		chk("dec_acc", {mem_wr.we, acc}, {1'b0, 8'h7F});
		do_op(OP_CALL, 1'b0, 8'h00, 8'h00, 3'h0, 16'h0400);
		do_op(OP_RETURN, 1'b0, 8'h00, 8'h00);
		chk("ret", {pc, acc, ready}, {16'h014C, 8'h7F, 1'b0});
	endtask

	// Main sequence: hold reset for 12 cycles, let it settle, run scenarios.
	initial begin
		repeat (12) @(negedge sys_clk);
		resetn = 1'b1;
		repeat (4) @(negedge sys_clk);
		s_arith();
		s_logic();
		s_unary();
		s_decimal();
		s_flow();
		s_irq();
		s_low_byte();
		s_watchdog();
		s_mem_ops();
		final_report();
	end
endmodule
